// *** include/lped_defs.svh ***
/*
 * Offsets, field positions, reset values and widths of the leaf entry
 * decoder. Assumes the includer compiles SystemVerilog.
 */
`ifndef LPED_DEFS_SVH
`define LPED_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LPED_OFF_CTRL 12'h000
`define LPED_OFF_CAP 12'h004
`define LPED_OFF_STATUS 12'h008
`define LPED_OFF_ADDR_LO 12'h00C
`define LPED_OFF_ADDR_HI 12'h010
`define LPED_OFF_FAULTS 12'h014

// ----------------------------------------------------------------
// Leaf 4 KB entry fields
// ----------------------------------------------------------------
`define LPED_LF_PRESENT 0
`define LPED_LF_WRITE 1
`define LPED_LF_USER 2
`define LPED_LF_WRTHRU 3
`define LPED_LF_CINHIB 4
`define LPED_LF_ACCESSED 5
`define LPED_LF_DIRTY 6
`define LPED_LF_PATIDX 7
`define LPED_LF_GLOBAL 8
`define LPED_LF_ADDR_LSB 12
`define LPED_LF_NOEXEC 63

// ----------------------------------------------------------------
// Second-level entry fields
// ----------------------------------------------------------------
`define LPED_SL_EXEC 2
`define LPED_SL_EMT_LSB 3
`define LPED_SL_IGNORE_ATTRIBUTE_INDEX 6
`define LPED_SL_PSIZE 7

// ----------------------------------------------------------------
// Control bits and reset values
// ----------------------------------------------------------------
`define LPED_CTRL_WPE 0
`define LPED_CTRL_NXE 1
`define LPED_CTRL_SECOND_LEVEL_EXEC_ENABLE 2
`define LPED_CTRL_MEMORY_TYPE_ENABLE 3
`define LPED_CTRL_NESTED 4
`define LPED_CTRL_RST 5'h00
`define LPED_FAULTS_W 16

`endif

// *** include/lped_pkg.sv ***
/*
 * Types shared by the leaf entry decoder files.
 * Assumes lped_defs.svh is on the include path.
 */
package lped_pkg;

   typedef enum logic [1:0] {
      LPED_SL_PTE,
      LPED_SL_PDE,
      LPED_SL_PDPE
   } lped_sl_level_e;

   typedef struct packed {
      logic [63:0] entry;
      logic [63:0] sl_entry;
      lped_sl_level_e sl_level;
      logic user;
      logic write;
      logic exec;
      logic coherent;
   } lped_req_s;

   typedef struct packed {
      logic supervisor_write_protect_enable;
      logic no_execute_enable;
      logic second_level_exec_enable;
      logic memory_type_enable;
      logic nested;
   } lped_ctrl_s;

   typedef struct packed {
      logic sl_exec_ok;
      logic sl_emt_valid;
      logic [2:0] sl_emt;
      logic sl_ignore_attribute_index;
      logic sl_leaf;
      logic sl_size_ok;
   } lped_sl_s;

   typedef struct packed {
      logic present;
      logic fault;
      logic user_ok;
      logic write_ok;
      logic exec_ok;
      logic accessed;
      logic dirty;
      logic mt_valid;
      logic [2:0] mem_type;
      logic [51:0] page_addr;
      logic guest_addr;
      lped_sl_s sl;
   } lped_rsp_s;

endpackage

// *** core/lped_sl_gate.sv ***
/*
 * Second-level entry gating: which execute and memory-type fields count.
 * Assumes a purely combinational use by the decoder top.
 */
`include "lped_defs.svh"

module lped_sl_gate (
   input wire logic [63:0] i_sl_entry,
   input wire lped_pkg::lped_sl_level_e i_level,
   input wire logic i_exec_support,
   input wire logic i_exec_enable,
   input wire logic i_mt_support,
   input wire logic i_mt_enable,
   input wire logic [1:0] i_large_pages,
   output lped_pkg::lped_sl_s o_sl
);

   logic exec_live;
   logic mt_live;
   logic is_dir;

   always_comb begin
      exec_live = i_exec_support & i_exec_enable;
      mt_live = i_mt_support & i_mt_enable;
      is_dir = (i_level != lped_pkg::LPED_SL_PTE);
      o_sl.sl_exec_ok = exec_live ? i_sl_entry[`LPED_SL_EXEC] : 1'b1;
      o_sl.sl_emt_valid = mt_live;
      o_sl.sl_emt = mt_live ? i_sl_entry[`LPED_SL_EMT_LSB +: 3] : 3'h0;
      o_sl.sl_ignore_attribute_index = mt_live & i_sl_entry[`LPED_SL_IGNORE_ATTRIBUTE_INDEX];
      // Directory levels: size bit picks frame or next table
      o_sl.sl_leaf = is_dir ? i_sl_entry[`LPED_SL_PSIZE] : 1'b1;
      // Large frames are legal only where advertised
      o_sl.sl_size_ok = 1'b1;
      if (is_dir && i_sl_entry[`LPED_SL_PSIZE]) begin
         o_sl.sl_size_ok = (i_level == lped_pkg::LPED_SL_PDPE) ?
            i_large_pages[1] : i_large_pages[0];
      end
   end

endmodule

// *** core/lped_top.sv ***
/*
 * Leaf 4 KB page entry decoder with an APB register slave.
 * Assumes the walker drives requests on i_clk; one result per request,
 * one cycle later.
 */
//
// Function
// - Global hint bit 8 is ignored, decoded as zero.
// - Bits 7,4,3 pick memory type for coherent requesters only.
// - Bit 6 reports a write-intent translation happened (dirty).
// - Bit 5 is the accessed flag.
// - Bit 2 clear refuses user-level requests.
// - Bit 1 clear denies user writes, supervisor too if protection on.
// - Entry maps a page only when bit 0 is one.
// - Second-level execute field ignored unless supported and enabled.
// - Second-level memory type fields ignored unless supported and enabled.
// - Capability register advertises 1 GB and 2 MB page support.
// - No-execute enable plus bit 63 denies execute.
// - Page address from bits width-1:12, guest-physical when nested.
`include "lped_defs.svh"

module lped_top #(
   parameter int HOST_ADDR_WIDTH = 48,
   parameter bit EXEC_SUPPORT = 1'b1,
   parameter bit MT_SUPPORT = 1'b1,
   parameter bit [1:0] LARGE_PAGES = 2'h3
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_req_valid,
   input wire lped_pkg::lped_req_s i_req,
   output logic o_rsp_valid,
   output lped_pkg::lped_rsp_s o_rsp
);

   // Mask shift below goes negative above 52; widths under 32 are also refused
   if (HOST_ADDR_WIDTH < 32 || HOST_ADDR_WIDTH > 52) begin : g_bad_haw
      $error("HOST_ADDR_WIDTH must lie in 32..52");
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   lped_pkg::lped_ctrl_s ctrl_reg;
   logic [`LPED_FAULTS_W-1:0] faults_reg;
   logic [`LPED_FAULTS_W-1:0] faults_next;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata_next;
   logic hit_next;
   logic rsp_valid_reg;
   lped_pkg::lped_rsp_s rsp_reg;
   lped_pkg::lped_rsp_s rsp_next;
   lped_pkg::lped_sl_s sl_dec;
   logic apb_access;
   logic apb_write;
   logic [51:0] addr_mask;

   assign apb_access = i_psel & i_penable & pready_reg;
   assign apb_write = apb_access & i_pwrite;

   // ----------------------------------------------------------------
   // Second-level gating
   // ----------------------------------------------------------------
   lped_sl_gate u_sl_gate (
      .i_sl_entry(i_req.sl_entry),
      .i_level(i_req.sl_level),
      .i_exec_support(EXEC_SUPPORT),
      .i_exec_enable(ctrl_reg.second_level_exec_enable),
      .i_mt_support(MT_SUPPORT),
      .i_mt_enable(ctrl_reg.memory_type_enable),
      .i_large_pages(LARGE_PAGES),
      .o_sl(sl_dec)
   );

   // ----------------------------------------------------------------
   // Leaf decode
   // ----------------------------------------------------------------
   always_comb begin
      addr_mask = 52'hF_FFFF_FFFF_FFFF >> (52 - HOST_ADDR_WIDTH);
      rsp_next.present = i_req.entry[`LPED_LF_PRESENT];
      rsp_next.user_ok = ~i_req.user | i_req.entry[`LPED_LF_USER];
      // Supervisor writes pass a read-only page unless protection is on
      rsp_next.write_ok = i_req.entry[`LPED_LF_WRITE] |
         (~i_req.user & ~ctrl_reg.supervisor_write_protect_enable);
      rsp_next.exec_ok = ~(ctrl_reg.no_execute_enable &
         i_req.entry[`LPED_LF_NOEXEC]);
      rsp_next.accessed = i_req.entry[`LPED_LF_ACCESSED];
      rsp_next.dirty = i_req.entry[`LPED_LF_DIRTY];
      rsp_next.mt_valid = i_req.coherent;
      rsp_next.mem_type = i_req.coherent ?
         {i_req.entry[`LPED_LF_PATIDX], i_req.entry[`LPED_LF_CINHIB],
          i_req.entry[`LPED_LF_WRTHRU]} : 3'h0;
      // Bit 8 never reaches any output, so the entry acts as non-global
      rsp_next.page_addr = {i_req.entry[51:`LPED_LF_ADDR_LSB], 12'h000}
         & addr_mask;
      rsp_next.guest_addr = ctrl_reg.nested;
      rsp_next.sl = sl_dec;
      rsp_next.fault = ~rsp_next.present | ~rsp_next.user_ok |
         (i_req.write & ~rsp_next.write_ok) |
         (i_req.exec & ~rsp_next.exec_ok);
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rsp_valid_reg <= 1'b0;
      end else begin
         rsp_valid_reg <= i_req_valid;
      end
   end

   // Result held until the next request so software can read it back
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rsp_reg <= '0;
      end else if (i_req_valid) begin
         rsp_reg <= rsp_next;
      end
   end

   // ----------------------------------------------------------------
   // Fault counter, saturating; a new fault beats a clear
   // ----------------------------------------------------------------
   always_comb begin
      faults_next = faults_reg;
      if (apb_write && i_paddr == `LPED_OFF_FAULTS) begin
         faults_next = '0;
      end
      if (i_req_valid && rsp_next.fault && faults_next != '1) begin
         faults_next = faults_next + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         faults_reg <= '0;
      end else begin
         faults_reg <= faults_next;
      end
   end

   // ----------------------------------------------------------------
   // APB slave: one wait state, pready one cycle into access
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_reg <= `LPED_CTRL_RST;
      end else if (apb_write && i_paddr == `LPED_OFF_CTRL && i_pstrb[0]) begin
         ctrl_reg.supervisor_write_protect_enable <= i_pwdata[`LPED_CTRL_WPE];
         ctrl_reg.no_execute_enable <= i_pwdata[`LPED_CTRL_NXE];
         ctrl_reg.second_level_exec_enable <= i_pwdata[`LPED_CTRL_SECOND_LEVEL_EXEC_ENABLE];
         ctrl_reg.memory_type_enable <= i_pwdata[`LPED_CTRL_MEMORY_TYPE_ENABLE];
         ctrl_reg.nested <= i_pwdata[`LPED_CTRL_NESTED];
      end
   end

   always_comb begin
      rdata_next = 32'h0000_0000;
      hit_next = 1'b1;
      case (i_paddr)
         `LPED_OFF_CTRL: begin
            rdata_next[`LPED_CTRL_WPE] = ctrl_reg.supervisor_write_protect_enable;
            rdata_next[`LPED_CTRL_NXE] = ctrl_reg.no_execute_enable;
            rdata_next[`LPED_CTRL_SECOND_LEVEL_EXEC_ENABLE] = ctrl_reg.second_level_exec_enable;
            rdata_next[`LPED_CTRL_MEMORY_TYPE_ENABLE] = ctrl_reg.memory_type_enable;
            rdata_next[`LPED_CTRL_NESTED] = ctrl_reg.nested;
         end
         `LPED_OFF_CAP: begin
            rdata_next[3:0] = {LARGE_PAGES, MT_SUPPORT, EXEC_SUPPORT};
         end
         `LPED_OFF_STATUS: begin
            rdata_next[15:0] = {rsp_reg.sl.sl_size_ok, rsp_reg.sl.sl_leaf,
               rsp_reg.guest_addr, rsp_reg.mem_type, rsp_reg.mt_valid,
               rsp_reg.dirty, rsp_reg.accessed, rsp_reg.exec_ok,
               rsp_reg.write_ok, rsp_reg.user_ok, rsp_reg.fault,
               rsp_reg.present, rsp_reg.sl.sl_exec_ok,
               rsp_reg.sl.sl_ignore_attribute_index};
         end
         `LPED_OFF_ADDR_LO: begin
            rdata_next = rsp_reg.page_addr[31:0];
         end
         `LPED_OFF_ADDR_HI: begin
            rdata_next[19:0] = rsp_reg.page_addr[51:32];
         end
         `LPED_OFF_FAULTS: begin
            rdata_next[`LPED_FAULTS_W-1:0] = faults_reg;
         end
         default: begin
            hit_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= i_psel & i_penable & ~pready_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (i_psel && i_penable && !pready_reg) begin
         prdata_reg <= i_pwrite ? 32'h0000_0000 : rdata_next;
         // Read-only and unmapped writes answer with an error
         pslverr_reg <= ~hit_next | (i_pwrite &&
            i_paddr != `LPED_OFF_CTRL && i_paddr != `LPED_OFF_FAULTS);
      end else begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
   end

   assign o_prdata = prdata_reg;
   assign o_pready = pready_reg;
   assign o_pslverr = pslverr_reg;
   assign o_rsp_valid = rsp_valid_reg;
   assign o_rsp = rsp_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_global_ignored;
      @(posedge i_clk) disable iff (!i_rstn)
      i_req_valid |=>
         o_rsp.page_addr[11:0] == 12'h000 && o_rsp_valid;
   endproperty
   a_global_ignored: assert property (p_global_ignored)
      else $error("Global bit leaked into page result");

   property p_mem_type;
      @(posedge i_clk) disable iff (!i_rstn)
      i_req_valid |=> o_rsp.mt_valid == $past(i_req.coherent) &&
         o_rsp.mem_type == ($past(i_req.coherent) ?
         {$past(i_req.entry[7]), $past(i_req.entry[4]),
          $past(i_req.entry[3])} : 3'h0);
   endproperty
   a_mem_type: assert property (p_mem_type)
      else $error("Memory type selection wrong");

   property p_dirty_accessed;
      @(posedge i_clk) disable iff (!i_rstn)
      i_req_valid |=> o_rsp.dirty == $past(i_req.entry[6]) &&
         o_rsp.accessed == $past(i_req.entry[5]);
   endproperty
   a_dirty_accessed: assert property (p_dirty_accessed)
      else $error("Dirty or accessed flag wrong");

   property p_user_refused;
      @(posedge i_clk) disable iff (!i_rstn)
      i_req_valid && i_req.user && !i_req.entry[2] |=>
         o_rsp_valid && o_rsp.fault && !o_rsp.user_ok;
   endproperty
   a_user_refused: assert property (p_user_refused)
      else $error("User request to supervisor page not refused");

   property p_write_denied;
      @(posedge i_clk) disable iff (!i_rstn)
      i_req_valid && !i_req.entry[1] && (i_req.user || ctrl_reg.supervisor_write_protect_enable) |=>
         !o_rsp.write_ok;
   endproperty
   a_write_denied: assert property (p_write_denied)
      else $error("Write permitted to read-only page");

   property p_not_present;
      @(posedge i_clk) disable iff (!i_rstn)
      i_req_valid |=> o_rsp.present == $past(i_req.entry[0]) &&
         (o_rsp.present || o_rsp.fault);
   endproperty
   a_not_present: assert property (p_not_present)
      else $error("Non-present entry not faulted");

   property p_sl_exec;
      @(posedge i_clk) disable iff (!i_rstn)
      i_req_valid && !(EXEC_SUPPORT && ctrl_reg.second_level_exec_enable) |=>
         o_rsp.sl.sl_exec_ok;
   endproperty
   a_sl_exec: assert property (p_sl_exec)
      else $error("Second-level execute field not ignored");

   property p_sl_mt;
      @(posedge i_clk) disable iff (!i_rstn)
      i_req_valid && !(MT_SUPPORT && ctrl_reg.memory_type_enable) |=>
         !o_rsp.sl.sl_emt_valid && o_rsp.sl.sl_emt == 3'h0 &&
         !o_rsp.sl.sl_ignore_attribute_index;
   endproperty
   a_sl_mt: assert property (p_sl_mt)
      else $error("Second-level memory type not ignored");

   property p_no_exec;
      @(posedge i_clk) disable iff (!i_rstn)
      i_req_valid && ctrl_reg.no_execute_enable && i_req.entry[63] && i_req.exec |=>
         !o_rsp.exec_ok && o_rsp.fault;
   endproperty
   a_no_exec: assert property (p_no_exec)
      else $error("Execute allowed on no-execute page");

   property p_guest_addr;
      @(posedge i_clk) disable iff (!i_rstn)
      i_req_valid |=> o_rsp.guest_addr == $past(ctrl_reg.nested) &&
         o_rsp.page_addr[20:12] == $past(i_req.entry[20:12]);
   endproperty
   a_guest_addr: assert property (p_guest_addr)
      else $error("Page address or nesting flag wrong");

   property p_sl_leaf;
      @(posedge i_clk) disable iff (!i_rstn)
      i_req_valid && i_req.sl_level != lped_pkg::LPED_SL_PTE |=>
         o_rsp.sl.sl_leaf == $past(i_req.sl_entry[7]);
   endproperty
   a_sl_leaf: assert property (p_sl_leaf)
      else $error("Directory size bit misread");

   property p_sl_size;
      @(posedge i_clk) disable iff (!i_rstn)
      i_req_valid && i_req.sl_level == lped_pkg::LPED_SL_PDE &&
         i_req.sl_entry[7] |=> o_rsp.sl.sl_size_ok == LARGE_PAGES[0];
   endproperty
   a_sl_size: assert property (p_sl_size)
      else $error("Large page legality flag wrong");

   property p_apb_wait;
      @(posedge i_clk) disable iff (!i_rstn)
      i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait)
      else $error("APB ready not a single pulse after one wait");

endmodule

// *** test/lped_walker.sv ***
/*
 * Translation walker model that feeds decode requests to the decoder.
 * Assumes the bench calls send and idle from one process on i_clk.
 */
module lped_walker (
   input wire logic i_clk,
   output logic o_req_valid,
   output lped_pkg::lped_req_s o_req
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_req_valid = 1'b0;
      o_req = '0;
   end

   // -------------------------------------------------------------
   // Request driving
   // -------------------------------------------------------------
   task automatic send(input lped_pkg::lped_req_s r);
      @(posedge i_clk);
      o_req_valid <= 1'b1;
      o_req <= r;
   endtask

   task automatic idle();
      @(posedge i_clk);
      o_req_valid <= 1'b0;
      // Flipped so a decoder sampling a dead request is caught
      o_req <= ~o_req;
   endtask
endmodule

// *** test/tb_top.sv ***
/*
 * Self-checking bench for the leaf entry decoder: APB register access
 * and decode requests through the walker model.
 * Assumes lped_pkg and the decoder files are compiled first.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int HOST_ADDRESS_WIDTH = 40;
   localparam bit [1:0] LP = 2'h2;
   localparam logic [51:0] AMASK = ((52'h1 << HOST_ADDRESS_WIDTH) - 52'h1) & ~52'hFFF;

   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic req_valid;
   lped_pkg::lped_req_s req;
   logic rsp_valid;
   lped_pkg::lped_rsp_s rsp;
   lped_pkg::lped_ctrl_s ctrl = '0;
   lped_pkg::lped_rsp_s last;
   int fail_count = 0;
   int tests_run = 0;
   int nflt = 0;
   logic [63:0] ent [4] = '{64'h8000_00AB_CDEF_F1FF, 64'h0000_0001_2345_6000,
                            64'hFFF0_0000_0000_0067, 64'h0000_00FF_FFFF_F19D};
   logic [63:0] sle [4] = '{64'h0FF, 64'h000, 64'h084, 64'h078};

   always #2 i_clk = ~i_clk;

   lped_top #(.HOST_ADDR_WIDTH(HOST_ADDRESS_WIDTH), .EXEC_SUPPORT(1'b1), .MT_SUPPORT(1'b1),
              .LARGE_PAGES(LP)) u_dut (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_req_valid(req_valid), .i_req(req),
      .o_rsp_valid(rsp_valid), .o_rsp(rsp));

   lped_walker u_walk (.i_clk(i_clk), .o_req_valid(req_valid), .o_req(req));

   // -------------------------------------------------------------
   // Checking and bus tasks
   // -------------------------------------------------------------
   task automatic conclude();
      $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [127:0] g, x, input string m);
      tests_run++;
      if (g !== x) begin
         $display("[FAIL] t=%0t %s got %0h exp %0h", $time, m, g, x);
         fail_count++;
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge i_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge i_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         conclude();
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x,
                     input logic xe);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, 4'h0, q, e);
      chk(e, xe, "read error flag");
      if (!xe) chk(q, x, "read data");
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic xe);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, s, q, e);
      chk(e, xe, "write error flag");
   endtask

   // -------------------------------------------------------------
   // Expected decode, worked out independently
   // -------------------------------------------------------------
   function automatic lped_pkg::lped_rsp_s exp_rsp(lped_pkg::lped_req_s r,
                                                   lped_pkg::lped_ctrl_s c);
      lped_pkg::lped_rsp_s e;
      logic lf;
      e = '0;
      e.present = r.entry[0];
      e.user_ok = !r.user | r.entry[2];
      e.write_ok = r.entry[1] | (!r.user & !c.supervisor_write_protect_enable);
      e.exec_ok = !(c.no_execute_enable & r.entry[63]);
      e.fault = !e.present | (r.user & !r.entry[2]) |
                (r.write & !e.write_ok) | (r.exec & !e.exec_ok);
      e.accessed = r.entry[5];
      e.dirty = r.entry[6];
      e.mt_valid = r.coherent;
      e.mem_type = r.coherent ? {r.entry[7], r.entry[4], r.entry[3]} : 3'h0;
      e.page_addr = r.entry[51:0] & AMASK;
      e.guest_addr = c.nested;
      e.sl.sl_exec_ok = c.second_level_exec_enable ? r.sl_entry[2] : 1'b1;
      e.sl.sl_emt_valid = c.memory_type_enable;
      e.sl.sl_emt = c.memory_type_enable ? r.sl_entry[5:3] : 3'h0;
      e.sl.sl_ignore_attribute_index = c.memory_type_enable & r.sl_entry[6];
      lf = (r.sl_level == lped_pkg::LPED_SL_PTE) | r.sl_entry[7];
      e.sl.sl_leaf = lf;
      e.sl.sl_size_ok =
         !(lf && r.sl_level == lped_pkg::LPED_SL_PDE && !LP[0]) &&
         !(lf && r.sl_level == lped_pkg::LPED_SL_PDPE && !LP[1]);
      return e;
   endfunction

   task automatic dec(input lped_pkg::lped_req_s r);
      lped_pkg::lped_rsp_s e;
      lped_pkg::lped_rsp_s g;
      lped_pkg::lped_rsp_s raw;
      e = exp_rsp(r, ctrl);
      u_walk.send(r);
      u_walk.idle();
      #1;
      raw = rsp;
      g = rsp;
      chk(rsp_valid, 1'b1, "response pulse");
      chk(g, e, "decode");
      @(posedge i_clk);
      #1;
      chk(rsp_valid, 1'b0, "pulse width");
      chk(rsp, raw, "response hold");
      nflt += e.fault;
      last = e;
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      lped_pkg::lped_req_s r;
      lped_pkg::lped_req_s r2;
      lped_pkg::lped_rsp_s ea;
      lped_pkg::lped_rsp_s eb;
      repeat (4) @(posedge i_clk);
      i_rstn <= 1'b1;
      rd(12'h000, 32'h0, 1'b0);
      rd(12'h004, 32'h0000_000B, 1'b0);
      rd(12'h008, 32'h0, 1'b0);
      rd(12'h00C, 32'h0, 1'b0);
      rd(12'h014, 32'h0, 1'b0);
      wr(12'h004, 32'h0000_0000, 4'hF, 1'b1);
      rd(12'h004, 32'h0000_000B, 1'b0);
      rd(12'h018, 32'h0, 1'b1);
      wr(12'h000, 32'h0000_001F, 4'h0, 1'b0);
      rd(12'h000, 32'h0, 1'b0);
      for (int c = 0; c < 32; c++) begin
         wr(12'h000, c, 4'hF, 1'b0);
         ctrl = '{supervisor_write_protect_enable: c[0], no_execute_enable: c[1], second_level_exec_enable: c[2], memory_type_enable: c[3], nested: c[4]};
         for (int k = 0; k < 16; k++) begin
            r = '0;
            r.entry = ent[k % 4] ^ (c[0] ? 64'h100 : 64'h0);
            r.sl_entry = sle[k / 4];
            r.sl_level = lped_pkg::lped_sl_level_e'(k % 3);
            r.user = k[0];
            r.write = k[1];
            r.exec = k[2];
            r.coherent = k[3];
            dec(r);
         end
      end
      rd(12'h008, {16'h0, last.sl.sl_size_ok, last.sl.sl_leaf,
         last.guest_addr, last.mem_type, last.mt_valid, last.dirty,
         last.accessed, last.exec_ok, last.write_ok, last.user_ok,
         last.fault, last.present, last.sl.sl_exec_ok, last.sl.sl_ignore_attribute_index},
         1'b0);
      rd(12'h00C, last.page_addr[31:0], 1'b0);
      rd(12'h010, {12'h0, last.page_addr[51:32]}, 1'b0);
      rd(12'h014, nflt[31:0], 1'b0);
      wr(12'h014, 32'h0, 4'hF, 1'b0);
      rd(12'h014, 32'h0, 1'b0);
      // Back to back: execute denied, then a clean user read
      r = '0;
      r.entry = ent[2];
      r.user = 1'b1;
      r.exec = 1'b1;
      r2 = '0;
      r2.entry = ent[3];
      r2.user = 1'b1;
      r2.coherent = 1'b1;
      ea = exp_rsp(r, ctrl);
      eb = exp_rsp(r2, ctrl);
      u_walk.send(r);
      u_walk.send(r2);
      #1;
      chk(rsp, ea, "first of pair");
      u_walk.idle();
      #1;
      chk(rsp_valid, 1'b1, "second pulse");
      chk(rsp, eb, "second of pair");
      rd(12'h014, ea.fault + eb.fault, 1'b0);
      conclude();
   end
endmodule
